/* File: slp_pkg.sv */
`default_nettype none
package slp_pkg;

	// ****************************************************************
	// Lane line states and timing
	// ****************************************************************

	// Low-power line pair levels, bit 1 is the positive wire.
	localparam logic [1:0] LP_STOP = 2'h3;
	localparam logic [1:0] LP_HS_RQ = 2'h1;
	localparam logic [1:0] LP_ULPS_RQ = 2'h2;
	localparam logic [1:0] LP_ZERO = 2'h0;

	// Transmit lane mode shown on the interconnect.
	localparam logic [1:0] TXM_STOP = 2'h0;
	localparam logic [1:0] TXM_LPDT = 2'h1;
	localparam logic [1:0] TXM_ULPS = 2'h2;
	localparam logic [1:0] TXM_TRIG = 2'h3;

	// Clock cycles per low-power bit on the serial lane.
	localparam int LP_BIT_CYCLES = 4;
	// Clock cycles without a DDR edge before the clock counts as lost.
	localparam int DDR_LOSS_CYCLES = 16;
	// Leader byte that opens a burst, earliest bit in bit 0.
	localparam logic [7:0] SYNC_BYTE = 8'hb8;
	// Bit counts of one byte: last and half DDR edge, and the low-power transmit bit count.
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [2:0] HALF_BIT = 3'h3;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// ****************************************************************
	// Controller register map, byte addresses
	// ****************************************************************

	localparam int ADDR_W = 5;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_TXDATA = 5'h04;
	localparam logic [4:0] REG_STATUS = 5'h08;
	localparam logic [4:0] REG_RXDATA = 5'h0c;
	localparam logic [4:0] REG_INT_STATUS = 5'h10;
	localparam logic [4:0] REG_INT_MASK = 5'h14;

	// Control register fields.
	localparam int CTRL_REQ = 0;
	localparam int CTRL_LPDT = 1;
	localparam int CTRL_ULPS = 2;
	localparam int CTRL_TRIG_LO = 4;

	// Interrupt bits.
	localparam int INT_RX_BYTE = 0;
	localparam int INT_SYNC = 1;
	localparam int INT_TX_DONE = 2;
	localparam int INT_TRIG = 3;
	localparam logic [3:0] INT_MASK_RESET = 4'h0;

	// Zero or one bit of a trigger field set.
	function automatic logic atMostOne(input logic [3:0] v);
		atMostOne = (v & (v - 4'h1)) == 4'h0;
	endfunction

	// Exactly one of the escape selects raised.
	function automatic logic oneSelect(input logic lpdt, input logic ulps,
		input logic [3:0] trig);
		logic [5:0] s;
		s = {lpdt, ulps, trig};
		oneSelect = (s != 6'h0) && ((s & (s - 6'h1)) == 6'h0);
	endfunction

endpackage
`default_nettype wire

/* File: slp_ppi_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface slp_ppi_if;

	logic txRequestEsc;
	logic txLpdtEsc;
	logic txUlpsEsc;
	logic [3:0] txTriggerEsc;
	logic [7:0] txDataEsc;
	logic txValidEsc;
	logic txReadyEsc;
	logic [3:0] rxTriggerEsc;
	logic clk_lane_ddr_clock_present;
	logic clk_lane_ultralow_n;
	logic rxByteClkHs;
	logic [7:0] rxDataHs;
	logic rxValidHs;
	logic rxActiveHs;
	logic rxSyncHs;

	modport lane (
		input txRequestEsc, txLpdtEsc, txUlpsEsc, txTriggerEsc,
		input txDataEsc, txValidEsc,
		output txReadyEsc, rxTriggerEsc,
		output clk_lane_ddr_clock_present, clk_lane_ultralow_n,
		output rxByteClkHs, rxDataHs, rxValidHs, rxActiveHs, rxSyncHs
	);

	modport proto (
		output txRequestEsc, txLpdtEsc, txUlpsEsc, txTriggerEsc,
		output txDataEsc, txValidEsc,
		input txReadyEsc, rxTriggerEsc,
		input clk_lane_ddr_clock_present, clk_lane_ultralow_n,
		input rxByteClkHs, rxDataHs, rxValidHs, rxActiveHs, rxSyncHs
	);

endinterface
`default_nettype wire

/* File: slp_lane.sv */
// How it works
// - Escape request plus trigger bit sends trigger.
// - Received trigger bit held until Stop state.
// - Protocol raises at most one trigger bit.
// - Eight-bit byte feeds low-power data mode.
// - Bit 0 goes onto the lane first.
// - Byte taken when request, valid, ready high.
// - Ready output shows the byte was accepted.
// - Clock lane flags a DDR clock present.
// - Ultra-low flag low from entry to Stop.
// - Byte clock divided from received DDR clock.
// - Protocol must not expect continuous byte clock.
// - Bytes delivered on byte clock, bit 0 earliest.
// - Protocol captures every byte while valid high.
// - No way to stall received bytes.
// - Receive-active high through whole burst.
// - Sync pulse one byte clock at burst start.
// - Escape request with exactly one select.
// - Low-power data mode lasts until request drops.
`timescale 1ns/1ps
`default_nettype none
module slp_lane #(
	parameter int LP_BIT_CYCLES = slp_pkg::LP_BIT_CYCLES,
	parameter int DDR_LOSS_CYCLES = slp_pkg::DDR_LOSS_CYCLES
) (
	input wire logic clk, // System clock, 50 MHz.
	input wire logic srst, // Synchronous reset, active high.
	slp_ppi_if.lane ppi, // Protocol side.
	input wire logic clkLaneDdr, // Clock lane DDR clock pin.
	input wire logic [1:0] clkLaneLp, // Clock lane low-power pins.
	input wire logic dataLaneHsBit, // Data lane high-speed bit pin.
	input wire logic [1:0] dataLaneLp, // Data lane low-power pins.
	input wire logic [3:0] dataLaneTrig, // Trigger seen on the data lane.
	output logic [1:0] laneTxMode, // Transmit lane mode.
	output logic laneTxBit, // Low-power data bit.
	output logic laneTxStb, // One-cycle strobe per data bit.
	output logic [3:0] laneTxTrig // Trigger being sent.
);

	// ****************************************************************
	// State
	// ****************************************************************

	typedef enum logic [1:0] {
		SLP_TX_IDLE = 2'b00,
		SLP_TX_LPDT = 2'b01,
		SLP_TX_ULPS = 2'b10,
		SLP_TX_TRIG = 2'b11
	} slp_tx_state_t;

	typedef struct packed {
		slp_tx_state_t txState;
		logic [7:0] txShift;
		logic [3:0] txBitsLeft;
		logic [7:0] txTimer;
		logic txReady;
		logic [1:0] txMode;
		logic txBit;
		logic txStb;
		logic [3:0] txTrig;
		logic [3:0] trigS1;
		logic [3:0] trigS2;
		logic [3:0] rxTrig;
		logic [2:0] ddrS;
		logic [1:0] bitS;
		logic [1:0] clkLpS1;
		logic [1:0] clkLpS2;
		logic [1:0] clkLpPrev;
		logic [1:0] datLpS1;
		logic [1:0] datLpS2;
		logic [7:0] ddrTimer;
		logic ddrPresent;
		logic ulpN;
		logic [7:0] assemble;
		logic [2:0] bitCnt;
		logic rxActive;
		logic rxSync;
		logic rxValid;
		logic [7:0] rxData;
		logic byteClk;
	} slp_lane_state_t;

	slp_lane_state_t s_reg, s_next;

	// Both timers are eight bits wide, so larger counts cannot be served.
	if (LP_BIT_CYCLES < 1 || LP_BIT_CYCLES > 255) begin : g_bad_bit
		$error("LP_BIT_CYCLES must be 1 to 255");
	end
	if (DDR_LOSS_CYCLES < 2 || DDR_LOSS_CYCLES > 255) begin : g_bad_loss
		$error("DDR_LOSS_CYCLES must be 2 to 255");
	end

	localparam logic [7:0] BIT_LAST = 8'(LP_BIT_CYCLES - 1);
	localparam logic [7:0] LOSS_LAST = 8'(DDR_LOSS_CYCLES - 1);

	// ****************************************************************
	// Next state
	// ****************************************************************

	// Transmit escape path, receive trigger hold, clock lane and HS receive.
	always_comb begin
		logic accept;
		logic ddrEdge;
		logic dataStop;
		logic [7:0] shifted;
		accept = 1'b0;
		ddrEdge = 1'b0;
		dataStop = 1'b0;
		shifted = 8'h0;
		s_next = s_reg;
		s_next.txStb = 1'b0;

		// Pins pass two flops; DDR edge and ULPS entry also read a third stage.
		s_next.trigS1 = dataLaneTrig;
		s_next.trigS2 = s_reg.trigS1;
		s_next.ddrS = {s_reg.ddrS[1:0], clkLaneDdr};
		s_next.bitS = {s_reg.bitS[0], dataLaneHsBit};
		s_next.clkLpS1 = clkLaneLp;
		s_next.clkLpS2 = s_reg.clkLpS1;
		s_next.clkLpPrev = s_reg.clkLpS2;
		s_next.datLpS1 = dataLaneLp;
		s_next.datLpS2 = s_reg.datLpS1;
		ddrEdge = s_reg.ddrS[1] ^ s_reg.ddrS[2];
		dataStop = s_reg.datLpS2 == slp_pkg::LP_STOP;

		unique case (s_reg.txState)
			SLP_TX_IDLE: begin
				s_next.txMode = slp_pkg::TXM_STOP;
				s_next.txTrig = 4'h0;
				if (ppi.txRequestEsc && slp_pkg::oneSelect(ppi.txLpdtEsc,
					ppi.txUlpsEsc, ppi.txTriggerEsc)) begin
					if (ppi.txLpdtEsc) begin
						s_next.txState = SLP_TX_LPDT;
						s_next.txMode = slp_pkg::TXM_LPDT;
						s_next.txReady = 1'b1;
					end else if (ppi.txUlpsEsc) begin
						s_next.txState = SLP_TX_ULPS;
						s_next.txMode = slp_pkg::TXM_ULPS;
					end else begin
						s_next.txState = SLP_TX_TRIG;
						s_next.txMode = slp_pkg::TXM_TRIG;
						s_next.txTrig = ppi.txTriggerEsc;
					end
				end
			end
			SLP_TX_LPDT: begin
				accept = ppi.txRequestEsc && ppi.txValidEsc && s_reg.txReady;
				if (accept) begin
					s_next.txShift = ppi.txDataEsc;
					s_next.txBitsLeft = slp_pkg::BYTE_BITS;
					s_next.txTimer = 8'h0;
					// ready drops while the byte shifts
					s_next.txReady = 1'b0;
				end else if (s_reg.txBitsLeft != 4'h0) begin
					if (s_reg.txTimer == BIT_LAST) begin
						s_next.txBit = s_reg.txShift[0];
						s_next.txStb = 1'b1;
						s_next.txShift = {1'b0, s_reg.txShift[7:1]};
						s_next.txBitsLeft = s_reg.txBitsLeft - 4'h1;
						s_next.txTimer = 8'h0;
						s_next.txReady = s_reg.txBitsLeft == 4'h1;
					end else begin
						s_next.txTimer = s_reg.txTimer + 8'h1;
					end
				end
				if (!ppi.txRequestEsc) begin
					s_next.txState = SLP_TX_IDLE;
					s_next.txMode = slp_pkg::TXM_STOP;
					s_next.txReady = 1'b0;
					s_next.txBitsLeft = 4'h0;
				end
			end
			SLP_TX_ULPS: begin
				if (!ppi.txRequestEsc) begin
					s_next.txState = SLP_TX_IDLE;
					s_next.txMode = slp_pkg::TXM_STOP;
				end
			end
			SLP_TX_TRIG: begin
				// trigger line stands until request drops
				if (!ppi.txRequestEsc) begin
					s_next.txState = SLP_TX_IDLE;
					s_next.txMode = slp_pkg::TXM_STOP;
					s_next.txTrig = 4'h0;
				end
			end
		endcase

		// trigger held to Stop, a new one wins
		if (dataStop)
			s_next.rxTrig = s_reg.trigS2;
		else
			s_next.rxTrig = s_reg.rxTrig | s_reg.trigS2;

		// DDR clock present while edges keep coming
		if (ddrEdge) begin
			s_next.ddrTimer = 8'h0;
			s_next.ddrPresent = 1'b1;
		end else if (s_reg.ddrTimer == LOSS_LAST) begin
			s_next.ddrPresent = 1'b0;
		end else begin
			s_next.ddrTimer = s_reg.ddrTimer + 8'h1;
		end

		// low from ULPS entry until Stop
		if (s_reg.clkLpS2 == slp_pkg::LP_STOP)
			s_next.ulpN = 1'b1;
		else if (s_reg.clkLpS2 == slp_pkg::LP_ZERO &&
			s_reg.clkLpPrev == slp_pkg::LP_ULPS_RQ)
			s_next.ulpN = 1'b0;

		// byte clock counts DDR edges, eight per byte
		shifted = {s_reg.bitS[1], s_reg.assemble[7:1]};
		if (s_reg.datLpS2 != slp_pkg::LP_ZERO) begin
			// burst ends when the lane leaves HS
			s_next.rxActive = 1'b0;
			s_next.rxValid = 1'b0;
			s_next.rxSync = 1'b0;
			s_next.byteClk = 1'b0;
			s_next.assemble = 8'h0;
		end else if (ddrEdge) begin
			s_next.assemble = shifted;
			if (!s_reg.rxActive) begin
				if (shifted == slp_pkg::SYNC_BYTE) begin
					// sync with first rise of active
					s_next.rxActive = 1'b1;
					s_next.rxSync = 1'b1;
					s_next.byteClk = 1'b1;
					s_next.bitCnt = 3'h0;
				end
			end else begin
				s_next.bitCnt = s_reg.bitCnt + 3'h1;
				if (s_reg.bitCnt == slp_pkg::HALF_BIT)
					s_next.byteClk = 1'b0;
				if (s_reg.bitCnt == slp_pkg::LAST_BIT) begin
					s_next.rxData = shifted;
					s_next.rxValid = 1'b1;
					s_next.rxSync = 1'b0;
					s_next.byteClk = 1'b1;
				end
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************

	// Reset clears every field but ulpN, which starts high, and the low-power line stages, which start in Stop.
	always_ff @(posedge clk) begin
		if (srst) begin
			s_reg <= '0;
			s_reg.ulpN <= 1'b1;
			s_reg.clkLpS1 <= slp_pkg::LP_STOP;
			s_reg.clkLpS2 <= slp_pkg::LP_STOP;
			s_reg.clkLpPrev <= slp_pkg::LP_STOP;
			s_reg.datLpS1 <= slp_pkg::LP_STOP;
			s_reg.datLpS2 <= slp_pkg::LP_STOP;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************

	// All outputs come straight from the state register.
	assign ppi.txReadyEsc = s_reg.txReady;
	assign ppi.rxTriggerEsc = s_reg.rxTrig;
	assign ppi.clk_lane_ddr_clock_present = s_reg.ddrPresent;
	assign ppi.clk_lane_ultralow_n = s_reg.ulpN;
	assign ppi.rxByteClkHs = s_reg.byteClk;
	assign ppi.rxDataHs = s_reg.rxData;
	assign ppi.rxValidHs = s_reg.rxValid;
	assign ppi.rxActiveHs = s_reg.rxActive;
	assign ppi.rxSyncHs = s_reg.rxSync;
	assign laneTxMode = s_reg.txMode;
	assign laneTxBit = s_reg.txBit;
	assign laneTxStb = s_reg.txStb;
	assign laneTxTrig = s_reg.txTrig;

endmodule
`default_nettype wire

/* File: slp_protocol.sv */
`timescale 1ns/1ps
`default_nettype none
module slp_protocol (
	input wire logic clk, // System clock, 50 MHz.
	input wire logic srst, // Synchronous reset, active high.
	slp_ppi_if.proto ppi, // Lane side.
	input wire logic [4:0] avs_address, // Byte address.
	input wire logic avs_read, // Read request.
	input wire logic avs_write, // Write request.
	input wire logic [31:0] avs_writedata, // Write data.
	output logic [31:0] avs_readdata, // Read data.
	output logic avs_waitrequest, // Stall, low for one answer cycle.
	output logic irq // Level interrupt.
);

	// ****************************************************************
	// State
	// ****************************************************************

	typedef struct packed {
		logic waitReq;
		logic [31:0] readData;
		logic req;
		logic lpdt;
		logic ulps;
		logic [3:0] trig;
		logic [7:0] txData;
		logic txValid;
		logic [7:0] rxByte;
		logic byteClkPrev;
		logic [3:0] trigPrev;
		logic [3:0] intSt;
		logic [3:0] intMask;
		logic irq;
	} slp_proto_state_t;

	slp_proto_state_t s_reg, s_next;

	// ****************************************************************
	// Next state
	// ****************************************************************

	// Bus slave, escape request drive and receive capture.
	always_comb begin
		logic take;
		logic wr;
		logic rise;
		logic [3:0] ev;
		logic [3:0] f;
		take = avs_waitrequest && (avs_read || avs_write);
		wr = take && avs_write;
		rise = ppi.rxByteClkHs && !s_reg.byteClkPrev;
		ev = 4'h0;
		f = avs_writedata[slp_pkg::CTRL_TRIG_LO +: 4];
		s_next = s_reg;
		s_next.byteClkPrev = ppi.rxByteClkHs;
		s_next.trigPrev = ppi.rxTriggerEsc;
		// One answer cycle after each request is seen.
		s_next.waitReq = !take;

		// lane took the byte, free the holder
		if (s_reg.txValid && ppi.txReadyEsc && s_reg.req) begin
			s_next.txValid = 1'b0;
			ev[slp_pkg::INT_TX_DONE] = 1'b1;
		end
		// capture on every valid rising byte clock
		if (rise && ppi.rxValidHs) begin
			s_next.rxByte = ppi.rxDataHs;
			ev[slp_pkg::INT_RX_BYTE] = 1'b1;
		end
		if (rise && ppi.rxSyncHs)
			ev[slp_pkg::INT_SYNC] = 1'b1;
		if ((ppi.rxTriggerEsc & ~s_reg.trigPrev) != 4'h0)
			ev[slp_pkg::INT_TRIG] = 1'b1;

		if (wr) begin
			unique case (avs_address)
				slp_pkg::REG_CTRL: begin
					s_next.lpdt = avs_writedata[slp_pkg::CTRL_LPDT];
					s_next.ulps = avs_writedata[slp_pkg::CTRL_ULPS];
					// more than one trigger bit is refused
					s_next.trig = slp_pkg::atMostOne(f) ? f : 4'h0;
					// request only with exactly one select
					s_next.req = avs_writedata[slp_pkg::CTRL_REQ] &&
						slp_pkg::oneSelect(s_next.lpdt, s_next.ulps,
						s_next.trig);
				end
				slp_pkg::REG_TXDATA: begin
					if (!s_reg.txValid) begin
						s_next.txData = avs_writedata[7:0];
						s_next.txValid = 1'b1;
					end
				end
				slp_pkg::REG_INT_MASK:
					s_next.intMask = avs_writedata[3:0];
				default: ;
			endcase
		end
		// Write one to clear; a new event in the same cycle wins.
		if (wr && avs_address == slp_pkg::REG_INT_STATUS)
			s_next.intSt = (s_reg.intSt & ~avs_writedata[3:0]) | ev;
		else
			s_next.intSt = s_reg.intSt | ev;
		s_next.irq = (s_next.intSt & s_next.intMask) != 4'h0;

		// Unmapped addresses read as zero.
		s_next.readData = 32'h0;
		if (take && avs_read) begin
			unique case (avs_address)
				slp_pkg::REG_CTRL:
					s_next.readData = {24'h0, s_reg.trig, 1'b0,
						s_reg.ulps, s_reg.lpdt, s_reg.req};
				slp_pkg::REG_TXDATA:
					s_next.readData = {24'h0, s_reg.txData};
				slp_pkg::REG_STATUS:
					s_next.readData = {20'h0, ppi.rxTriggerEsc,
						3'h0, s_reg.txValid, ppi.rxActiveHs,
						ppi.clk_lane_ultralow_n,
						ppi.clk_lane_ddr_clock_present,
						ppi.txReadyEsc};
				slp_pkg::REG_RXDATA:
					s_next.readData = {24'h0, s_reg.rxByte};
				slp_pkg::REG_INT_STATUS:
					s_next.readData = {28'h0, s_reg.intSt};
				slp_pkg::REG_INT_MASK:
					s_next.readData = {28'h0, s_reg.intMask};
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************

	// Waitrequest idles high so a request is held until answered.
	always_ff @(posedge clk) begin
		if (srst) begin
			s_reg <= '0;
			s_reg.waitReq <= 1'b1;
			s_reg.intMask <= slp_pkg::INT_MASK_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs from the state register; the escape selects are gated by req.
	assign avs_readdata = s_reg.readData;
	assign avs_waitrequest = s_reg.waitReq;
	assign irq = s_reg.irq;
	assign ppi.txRequestEsc = s_reg.req;
	assign ppi.txLpdtEsc = s_reg.req && s_reg.lpdt;
	assign ppi.txUlpsEsc = s_reg.req && s_reg.ulps;
	assign ppi.txTriggerEsc = s_reg.req ? s_reg.trig : 4'h0;
	assign ppi.txDataEsc = s_reg.txData;
	assign ppi.txValidEsc = s_reg.txValid;

endmodule
`default_nettype wire

/* File: slp_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module slp_checker (
	input wire logic clk, // System clock.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic txRequestEsc, // Escape request.
	input wire logic txLpdtEsc, // Low-power data select.
	input wire logic txUlpsEsc, // Ultra-low select.
	input wire logic [3:0] txTriggerEsc, // Trigger select.
	input wire logic txValidEsc, // Byte offered.
	input wire logic txReadyEsc, // Lane can take a byte.
	input wire logic rxByteClkHs, // Receive byte clock.
	input wire logic rxValidHs, // Receive byte valid.
	input wire logic rxActiveHs, // Burst active.
	input wire logic rxSyncHs // Sync observed.
);

	// ****************************************************************
	// Escape transmit handshake
	// ****************************************************************

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// A byte changes hands only when all three strobes meet.
	sequence s_take;
		txRequestEsc && txValidEsc && txReadyEsc;
	endsequence

	// The burst opens on the first rise of the active flag.
	sequence s_burst_open;
		$rose(rxActiveHs);
	endsequence

	AST_ACCEPT_DROP: assert property (s_take |=> !txReadyEsc [*8])
		else $error("ready did not stay low while the byte shifts out");
	AST_READY_BACK: assert property (s_take |-> ##[2:200]
		(txReadyEsc || !txRequestEsc))
		else $error("ready never returned after a byte");
	AST_ONE_TRIG: assert property ($onehot0(txTriggerEsc))
		else $error("more than one trigger select raised");
	AST_REQ_ONE: assert property (txRequestEsc |->
		$onehot({txLpdtEsc, txUlpsEsc, txTriggerEsc}))
		else $error("escape request without exactly one select");

	// ****************************************************************
	// High-speed receive framing
	// ****************************************************************

	AST_SYNC_START: assert property (s_burst_open |-> rxSyncHs)
		else $error("sync missing at burst start");
	AST_SYNC_ONCE: assert property ($rose(rxByteClkHs) &&
		!$rose(rxActiveHs) |-> !rxSyncHs)
		else $error("sync high past the first byte clock");
	AST_SYNC_IN_ACTIVE: assert property (rxSyncHs |-> rxActiveHs)
		else $error("sync outside an active burst");
	AST_VALID_ACTIVE: assert property (rxValidHs |-> rxActiveHs)
		else $error("valid outside an active burst");
	AST_BYTECLK_HS: assert property (rxByteClkHs |-> rxActiveHs)
		else $error("byte clock high outside a burst");

endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
	err_total++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;

	// ****************************************************************
	// Signals
	// ****************************************************************

	logic clk;
	logic srst = 1'b1;
	logic clkLaneDdr = 1'b0;
	logic [1:0] clkLaneLp = 2'h3;
	logic dataLaneHsBit = 1'b0;
	logic [1:0] dataLaneLp = 2'h3;
	logic [3:0] dataLaneTrig = 4'h0;
	logic [1:0] laneTxMode;
	logic laneTxBit;
	logic laneTxStb;
	logic [3:0] laneTxTrig;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	logic [31:0] rdData;
	logic [7:0] txShift = 8'h00;
	logic [7:0] rxGot = 8'h00;
	logic byteClkPrev = 1'b0;
	int txCount = 0;
	int rxCount = 0;
	int syncCount = 0;
	int err_total = 0;
	int total_checks = 0;

	slp_ppi_if ppi();
	slp_lane #(.LP_BIT_CYCLES(2), .DDR_LOSS_CYCLES(4)) i_slp_lane (
		.clk(clk), .srst(srst), .ppi(ppi), .clkLaneDdr(clkLaneDdr),
		.clkLaneLp(clkLaneLp), .dataLaneHsBit(dataLaneHsBit),
		.dataLaneLp(dataLaneLp), .dataLaneTrig(dataLaneTrig),
		.laneTxMode(laneTxMode), .laneTxBit(laneTxBit),
		.laneTxStb(laneTxStb), .laneTxTrig(laneTxTrig));
	slp_protocol i_slp_protocol (
		.clk(clk), .srst(srst), .ppi(ppi), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq));
	slp_checker i_slp_checker (
		.clk(clk), .srst(srst), .txRequestEsc(ppi.txRequestEsc),
		.txLpdtEsc(ppi.txLpdtEsc), .txUlpsEsc(ppi.txUlpsEsc),
		.txTriggerEsc(ppi.txTriggerEsc), .txValidEsc(ppi.txValidEsc),
		.txReadyEsc(ppi.txReadyEsc), .rxByteClkHs(ppi.rxByteClkHs),
		.rxValidHs(ppi.rxValidHs), .rxActiveHs(ppi.rxActiveHs),
		.rxSyncHs(ppi.rxSyncHs));

	// Free-running 50 MHz system clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ****************************************************************
	// Monitors and tasks
	// ****************************************************************

	// Collect serial bits and received bytes as the protocol would.
	always @(posedge clk) begin
		if (laneTxStb === 1'b1) begin
			txShift <= {laneTxBit, txShift[7:1]};
			txCount <= txCount + 1;
		end
		byteClkPrev <= ppi.rxByteClkHs;
		if (ppi.rxByteClkHs === 1'b1 && byteClkPrev === 1'b0) begin
			if (ppi.rxSyncHs === 1'b1) begin
				syncCount <= syncCount + 1;
			end
			if (ppi.rxValidHs === 1'b1) begin
				rxGot <= ppi.rxDataHs;
				rxCount <= rxCount + 1;
			end
		end
	end

	task automatic complete_run();
		if (err_total == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One Avalon transfer; the request holds until waitrequest is seen low.
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rdData = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK($sformatf("reg %h", a), e, rdData & m)
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Bounded wait so a silent lane cannot hang the run.
	task automatic wait_tx(input int c);
		for (int n = 0; n < 300 && txCount < c; n++) @(posedge clk);
	endtask

	// One byte on the DDR lane, earliest bit first, bit set before its edge.
	task automatic hs_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			dataLaneHsBit <= b[i];
			@(posedge clk);
			clkLaneDdr <= ~clkLaneDdr;
			@(posedge clk);
		end
	endtask

	// Cut a hung run short well past the expected few hundred cycles.
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		complete_run();
	end

	// ****************************************************************
	// Tests
	// ****************************************************************

	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		rd_chk(slp_pkg::REG_STATUS, 32'hfff, 32'h4);
		rd_chk(5'h1c, 32'hffffffff, 32'h0);
		// Every trigger code, sent and then held by the receiver.
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, slp_pkg::REG_CTRL, 32'h1 | (32'h10 << k));
			tick(4);
			`CHK("mode", slp_pkg::TXM_TRIG, laneTxMode)
			`CHK("trig", 4'h1 << k, laneTxTrig)
			dataLaneLp <= 2'h1;
			dataLaneTrig <= 4'h1 << k;
			tick(3);
			dataLaneTrig <= 4'h0;
			tick(6);
			rd_chk(slp_pkg::REG_STATUS, 32'hf00, 32'h100 << k);
			bus(1'b1, slp_pkg::REG_CTRL, 32'h0);
			dataLaneLp <= 2'h3;
			tick(6);
			rd_chk(slp_pkg::REG_STATUS, 32'hf00, 32'h0);
		end
		// Two trigger bits at once must leave the lane idle.
		bus(1'b1, slp_pkg::REG_CTRL, 32'h31);
		tick(4);
		`CHK("mode", slp_pkg::TXM_STOP, laneTxMode)
		bus(1'b1, slp_pkg::REG_CTRL, 32'h5);
		tick(24);
		`CHK("mode", slp_pkg::TXM_ULPS, laneTxMode)
		bus(1'b1, slp_pkg::REG_CTRL, 32'h0);
		tick(4);
		`CHK("mode", slp_pkg::TXM_STOP, laneTxMode)
		// Two low-power data bytes, then no stray strobes.
		bus(1'b1, slp_pkg::REG_CTRL, 32'h3);
		tick(4);
		`CHK("mode", slp_pkg::TXM_LPDT, laneTxMode)
		bus(1'b1, slp_pkg::REG_TXDATA, 32'ha5);
		wait_tx(8);
		`CHK("txbyte", 8'ha5, txShift)
		bus(1'b1, slp_pkg::REG_TXDATA, 32'h5a);
		wait_tx(16);
		`CHK("txbyte", 8'h5a, txShift)
		tick(40);
		`CHK("txcount", 16, txCount)
		`CHK("mode", slp_pkg::TXM_LPDT, laneTxMode)
		// Accept event raises, masks and clears the interrupt.
		rd_chk(slp_pkg::REG_INT_STATUS, 32'h4, 32'h4);
		rd_chk(slp_pkg::REG_INT_STATUS, 32'h8, 32'h8);
		bus(1'b1, slp_pkg::REG_INT_MASK, 32'h4);
		tick(3);
		`CHK("irq", 1'b1, irq)
		bus(1'b1, slp_pkg::REG_INT_MASK, 32'h0);
		tick(3);
		`CHK("irq", 1'b0, irq)
		bus(1'b1, slp_pkg::REG_INT_STATUS, 32'hf);
		rd_chk(slp_pkg::REG_INT_STATUS, 32'hf, 32'h0);
		bus(1'b1, slp_pkg::REG_CTRL, 32'h0);
		// Clock lane ultra-low entry and exit.
		clkLaneLp <= 2'h2;
		tick(4);
		clkLaneLp <= 2'h0;
		tick(6);
		rd_chk(slp_pkg::REG_STATUS, 32'h4, 32'h0);
		clkLaneLp <= 2'h3;
		tick(6);
		rd_chk(slp_pkg::REG_STATUS, 32'h4, 32'h4);
		// High-speed burst: leader then two data bytes.
		dataLaneLp <= 2'h0;
		tick(4);
		hs_byte(8'hb8);
		hs_byte(8'h3c);
		hs_byte(8'hc3);
		`CHK("ddr", 1'b1, ppi.clk_lane_ddr_clock_present)
		tick(6);
		`CHK("active", 1'b1, ppi.rxActiveHs)
		`CHK("rxbyte", 8'hc3, rxGot)
		`CHK("rxcount", 2, rxCount)
		`CHK("sync", 1, syncCount)
		dataLaneLp <= 2'h3;
		tick(20);
		`CHK("active", 1'b0, ppi.rxActiveHs)
		`CHK("ddr", 1'b0, ppi.clk_lane_ddr_clock_present)
		rd_chk(slp_pkg::REG_RXDATA, 32'hff, 32'hc3);
		rd_chk(slp_pkg::REG_INT_STATUS, 32'h3, 32'h3);
		complete_run();
	end

endmodule
`default_nettype wire
